// *** cdp_cfg.svh ***
`ifndef CDP_CFG_SVH
`define CDP_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CDP_CLK_MHZ      25
// standard filter delay, us, window 100..220
`define CDP_TD_MIN_US    100
`define CDP_TD_MAX_US    220
// extended blind times, us (typ 2.5 ms and 5 ms)
`define CDP_TD_EXT1_US   2500
`define CDP_TD_EXT2_US   5000
// reverse comparator re-arm delay, us
`define CDP_RCP_ON_US    24
// cycle counts derived from rate
`define CDP_TD_CYC       (`CDP_TD_MIN_US * `CDP_CLK_MHZ)
`define CDP_TD_EXT1_CYC  (`CDP_TD_EXT1_US * `CDP_CLK_MHZ)
`define CDP_TD_EXT2_CYC  (`CDP_TD_EXT2_US * `CDP_CLK_MHZ)
`define CDP_RCP_ON_CYC   (`CDP_RCP_ON_US * `CDP_CLK_MHZ)
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CDP_ADDR_CTRL    4'h0
`define CDP_ADDR_DIAG    4'h1
`define CDP_ADDR_CLR     4'h2
`define CDP_ADDR_IRQ_ST  4'h3
`define CDP_ADDR_IRQ_MSK 4'h4
`define CDP_ADDR_STATE   4'h5
// ----------------------------------------
// control field positions
// ----------------------------------------
`define CDP_CTRL_EXT     0
`define CDP_CTRL_LONG    1
`define CDP_CTRL_RCP     2
// ----------------------------------------
// reset values
// ----------------------------------------
`define CDP_CTRL_RST     3'h0
`define CDP_DIAG_RST     20'hfffff
`define CDP_MSK_RST      10'h000
`endif

// *** cdp_pkg.sv ***
package cdp_pkg;
  // two-bit per-channel diagnosis code
  typedef enum logic [1:0] {
    CDP_SHORT_GROUND_CODE  = 2'h0,
    CDP_OPEN_LOAD_CODE     = 2'h1,
    CDP_OVERLOAD_FAULT_CODE = 2'h2,
    CDP_NO_FAULT_CODE      = 2'h3
  } cdp_diag_e;
  // reverse comparator states
  typedef enum logic [1:0] {
    CDP_RC_IDLE,
    CDP_RC_DRIVE,
    CDP_RC_LOCK,
    CDP_RC_REARM
  } cdp_rc_e;
  // analog condition flags of one channel
  typedef struct packed {
    logic open_load;
    logic short_ground;
    logic overload;
    logic rev_cur;
    logic rev_over;
  } cdp_cond_s;
  // register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cdp_bus_s;
endpackage

// *** cdp_ctrl.sv ***
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "cdp_cfg.svh"
module cdp_ctrl
  import cdp_pkg::*;
#(
  parameter int NCH      = 10,
  parameter int TD_EXT1  = `CDP_TD_EXT1_CYC,
  parameter int TD_EXT2  = `CDP_TD_EXT2_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // channel pins
  input  wire logic [NCH-1:0]      channel_control_input,
  output logic      [NCH-1:0]      channel_power_output,
  // analog condition flags per channel
  input  wire cdp_cond_s [NCH-1:0] cond,
  // register port
  input  wire cdp_bus_s            bus,
  output logic      [31:0]         rdata,
  // interrupt
  output logic                     irq
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0]       ctrl_q;       // blind and comparator bits
  logic [2*NCH-1:0] diag_q;       // diagnosis codes
  logic [NCH-1:0]   ist_q;        // sticky event status
  logic [NCH-1:0]   imsk_q;       // interrupt mask
  logic [NCH-1:0]   latch_q;      // overload latch-off
  logic [NCH-1:0]   rc_on_q;      // comparator drive
  logic [NCH-1:0]   out_q;        // output stage
  logic [31:0]      rdata_q;      // read data
  logic             irq_q;        // interrupt level

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // write strobe aimed at one word
  function automatic logic hit(input cdp_bus_s b, input logic [3:0] a);
    return b.wr && (b.addr == a);
  endfunction

  wire blind_time_extend_bit          = ctrl_q[`CDP_CTRL_EXT];
  wire blind_time_long_select_bit     = ctrl_q[`CDP_CTRL_LONG];
  wire reverse_comparator_enable_bit  = ctrl_q[`CDP_CTRL_RCP];
  wire wr_ctrl  = hit(bus, `CDP_ADDR_CTRL);
  wire wr_clr   = hit(bus, `CDP_ADDR_CLR);
  wire wr_ist   = hit(bus, `CDP_ADDR_IRQ_ST);
  wire wr_msk   = hit(bus, `CDP_ADDR_IRQ_MSK);
  // a clear write counts as the diagnosis register write cycle
  wire diag_busy = wr_clr;
  // mask as it stands after this edge, so irq follows a mask write
  wire [NCH-1:0] msk_d = wr_msk ? bus.wdata[NCH-1:0] : imsk_q;

  logic [NCH-1:0] commit;   // new code this cycle
  logic [1:0]     code [NCH];

  // ----------------------------------------
  // per-channel filter, latch and comparator
  // ----------------------------------------
  // one slice per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      localparam bit EXT_CH = (g >= 6);  // channels 7 to 10
      logic [17:0] cnt_q;                // filter timer
      logic        run_q;                // filter running
      logic        pend_q;               // held event
      logic [1:0]  pcode_q;              // held code
      logic [9:0]  rc_cnt_q;             // re-arm timer
      cdp_rc_e     rc_q;
      logic [17:0] lim;
      wire         ol   = cond[g].open_load;
      wire         sg   = cond[g].short_ground;
      wire         fcnd = ol | sg;
      wire         fexp;
      wire [1:0]   fcode;
      wire         ev;
      wire [1:0]   ecode;

      // delay select; bit one ignored unless bit zero set
      assign lim = (EXT_CH && blind_time_extend_bit) ?
                   (blind_time_long_select_bit ? 18'(TD_EXT2)
                                               : 18'(TD_EXT1))
                   : 18'(`CDP_TD_CYC);
      // latest condition at expiry stored
      assign fexp  = run_q && fcnd && (cnt_q >= lim - 18'h1);
      assign fcode = sg ? CDP_SHORT_GROUND_CODE
                        : CDP_OPEN_LOAD_CODE;
      assign ev    = cond[g].overload | fexp | pend_q;
      assign ecode = cond[g].overload ? CDP_OVERLOAD_FAULT_CODE
                     : (fexp ? fcode : pcode_q);
      // commit unless a clear write is in progress
      assign commit[g] = ev && !diag_busy;
      assign code[g]   = ecode;

      // filter timer, not restarted on ol/sg swap
      always_ff @(posedge clk) begin
        if (srst || !fcnd || fexp) begin
          cnt_q <= 18'h0;
          run_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q + 18'h1;
          run_q <= 1'b1;
        end
      end

      // hold events arriving during diag write
      always_ff @(posedge clk) begin
        if (srst) begin
          pend_q  <= 1'b0;
          pcode_q <= 2'h3;
        end else if (ev && diag_busy) begin
          pend_q  <= 1'b1;
          pcode_q <= ecode;
        end else if (!diag_busy) begin
          pend_q  <= 1'b0;
        end
      end

      // reverse comparator sequencing
      always_ff @(posedge clk) begin
        if (srst || !reverse_comparator_enable_bit) begin
          rc_q     <= CDP_RC_IDLE;
          rc_cnt_q <= 10'h0;
        end else begin
          case (rc_q)
            CDP_RC_IDLE: begin
              // already beyond the limit: never drive
              if (cond[g].rev_over) rc_q <= CDP_RC_LOCK;
              else if (cond[g].rev_cur) rc_q <= CDP_RC_DRIVE;
            end
            CDP_RC_DRIVE:
              if (cond[g].rev_over) rc_q <= CDP_RC_LOCK;
              else if (!cond[g].rev_cur) rc_q <= CDP_RC_IDLE;
            CDP_RC_LOCK: begin
              rc_cnt_q <= 10'h0;
              if (!cond[g].rev_cur) rc_q <= CDP_RC_REARM;
            end
            CDP_RC_REARM: begin
              if (cond[g].rev_cur) begin
                rc_q <= CDP_RC_LOCK;
              end else if (rc_cnt_q == 10'(`CDP_RCP_ON_CYC - 1)) begin
                rc_q <= CDP_RC_IDLE;
              end
              rc_cnt_q <= rc_cnt_q + 10'h1;
            end
            default: rc_q <= CDP_RC_IDLE;
          endcase
        end
      end
      assign rc_on_q[g] = (rc_q == CDP_RC_DRIVE);
    end
  endgenerate

  // ----------------------------------------
  // diagnosis register and latch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst) begin
        diag_q[2*i +: 2] <= 2'h3;
        latch_q[i]       <= 1'b0;
      end else if (commit[i]) begin
        diag_q[2*i +: 2] <= code[i];
        latch_q[i] <= (code[i] == CDP_OVERLOAD_FAULT_CODE);
      end else if (wr_clr && bus.wdata[i]) begin
        diag_q[2*i +: 2] <= CDP_NO_FAULT_CODE;
        latch_q[i]       <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // outputs, input n drives output n
  // ----------------------------------------
  // latch masks the input, comparator drive overrides
  always_ff @(posedge clk) begin
    if (srst) out_q <= '0;
    else out_q <= (channel_control_input & ~latch_q)
                  | rc_on_q;
  end
  assign channel_power_output = out_q;

  // ----------------------------------------
  // control, interrupt registers; set wins
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `CDP_CTRL_RST;
      imsk_q <= `CDP_MSK_RST;
      ist_q  <= '0;
      irq_q  <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= bus.wdata[2:0];
      if (wr_msk)  imsk_q <= bus.wdata[NCH-1:0];
      ist_q <= (ist_q & ~(wr_ist ? bus.wdata[NCH-1:0] : '0)) | commit;
      irq_q <= |(((ist_q & ~(wr_ist ? bus.wdata[NCH-1:0] : '0))
                 | commit) & msk_d);
    end
  end
  assign irq = irq_q;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // unmapped words read as zero
  always_ff @(posedge clk) begin
    if (srst || !bus.rd) rdata_q <= 32'h0;
    else case (bus.addr)
      `CDP_ADDR_CTRL:    rdata_q <= {29'h0, ctrl_q};
      `CDP_ADDR_DIAG:    rdata_q <= 32'(diag_q);
      `CDP_ADDR_IRQ_ST:  rdata_q <= 32'(ist_q);
      `CDP_ADDR_IRQ_MSK: rdata_q <= 32'(imsk_q);
      `CDP_ADDR_STATE:   rdata_q <= 32'({latch_q, out_q});
      default:           rdata_q <= 32'h0;
    endcase
  end
  assign rdata = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // all checks on the one clock, quiet in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // low input and no comparator drive: pin off next cycle
  a_low_input_off: assert property (
    !channel_control_input[0] && !rc_on_q[0] |=> !channel_power_output[0])
    else $error("output on with input low");
  // latched channel stays off whatever its input does
  a_latch_forces_off: assert property (
    latch_q[2] && !rc_on_q[2] |=> !channel_power_output[2])
    else $error("latched channel driven");
  // overload lands as code 10 outside a clear write
  a_overload_code: assert property (
    cond[2].overload && !diag_busy |=> diag_q[5:4] == 2'h2)
    else $error("overload code missing");
  // comparator never drives while its enable is low
  a_rcp_disabled: assert property (
    !reverse_comparator_enable_bit |=> rc_on_q == '0)
    else $error("comparator active while disabled");
  // fresh open load not stored within eight cycles
  a_filter_short: assert property (
    $rose(cond[0].open_load) && !cond[0].short_ground
      && !cond[0].overload && diag_q[1:0] != 2'h1
      |=> (diag_q[1:0] != 2'h1) [*8])
    else $error("open load taken too early");
  // overload during a clear write committed one cycle late
  a_held_event: assert property (
    cond[3].overload && diag_busy
      ##1 !diag_busy && !cond[3].open_load && !cond[3].short_ground
      |=> diag_q[7:6] == 2'h2)
    else $error("held event lost");
  // unlatched channel follows its input
  a_input_follow: assert property (
    channel_control_input[4] && !latch_q[4] |=> channel_power_output[4])
    else $error("output not following input");
  // irq high while an unmasked status bit is set
  a_irq_level: assert property (
    (ist_q & imsk_q) != '0 |-> irq)
    else $error("irq low with pending status");
  // irq low while no unmasked status bit is set
  a_irq_quiet: assert property (
    (ist_q & imsk_q) == '0 |-> !irq)
    else $error("irq high with nothing pending");
  // clear write drops the overload latch
  a_clear_unlatch: assert property (
    wr_clr && bus.wdata[2] |=> !latch_q[2])
    else $error("latch survived clear");
  // excess reverse current stops comparator drive
  a_rev_release: assert property (
    cond[4].rev_over |=> !rc_on_q[4])
    else $error("comparator drives past its limit");
  // released comparator does not drive before re-arm
  a_lock_no_drive: assert property (
    g_ch[4].rc_q == CDP_RC_LOCK |=> !rc_on_q[4])
    else $error("comparator drives while locked");

  // main scenarios reached
  c_overload: cover property (cond[0].overload ##1 latch_q[0]);
  c_rcp_drive: cover property (rc_on_q[4]);
  c_clear: cover property (latch_q[2] && wr_clr ##1 !latch_q[2]);
  c_held_event: cover property (cond[3].overload && diag_busy);
  c_rearm_done: cover property (
    g_ch[4].rc_q == CDP_RC_REARM ##1 g_ch[4].rc_q == CDP_RC_IDLE);

endmodule
`default_nettype wire

// *** cdp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side: register master, channel pins
// ----------------------------------------
module cdp_host_model
  import cdp_pkg::*;
(
  // clock
  input  wire logic        clk,
  // register port
  output var  cdp_bus_s    bus,
  input  wire logic [31:0] rdata,
  // channel pins
  output var  logic [9:0]  chan_in
);
  // idle bus, all channels off
  initial begin
    bus = '0;
    chan_in = '0;
  end
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // one-cycle read strobe, data taken in the next cycle only
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cdp_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic            clk = 1'b0;  // 25 mhz
  logic            srst = 1'b1; // sync reset
  logic            irq;         // interrupt level
  logic [9:0]      outp;        // output stages
  logic [9:0]      chin;        // control inputs
  logic [31:0]     rdata;       // read data
  logic [31:0]     v;           // last read value
  cdp_cond_s [9:0] cond = '0;   // analog flags
  cdp_bus_s        bus;         // register request
  int              fail_count = 0;
  int              check_count = 0;
  // clock
  always #20 clk = ~clk;
  // short blind times keep the run brief
  cdp_ctrl #(.NCH(10), .TD_EXT1(50), .TD_EXT2(100)) cdp_ctrl_i (
    .clk(clk), .srst(srst), .channel_control_input(chin),
    .channel_power_output(outp), .cond(cond), .bus(bus),
    .rdata(rdata), .irq(irq));
  cdp_host_model cdp_host_model_i (
    .clk(clk), .bus(bus), .rdata(rdata), .chan_in(chin));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // wait n rising edges
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // register access through the host
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    cdp_host_model_i.wr(a, d);
  endtask
  // one channel's diagnosis field
  task automatic diag(input int ch, input logic [1:0] e);
    cdp_host_model_i.rd(4'h1, v);
    check(32'(v[2*ch +: 2]), 32'(e));
  endtask
  // one output stage, after edge updates land
  task automatic pin(input int ch, input logic e);
    #1 check(32'(outp[ch]), 32'(e));
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog
  initial begin
    w(40000);
    fail_count++;
    final_report;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    w(20);
    srst <= 1'b0;
    diag(9, CDP_NO_FAULT_CODE);
    cdp_host_model_i.rd(4'hf, v);
    check(v, 32'h0);
    // walking one across the control inputs
    for (int i = 0; i < 10; i++) begin
      w(1);
      cdp_host_model_i.chan_in <= 10'(1 << i);
      w(2);
      #1 check(32'(outp), 32'(1 << i));
    end
    // open load on channel 0, standard filter
    w(1);
    cdp_host_model_i.chan_in <= '0;
    cond[0].open_load <= 1'b1;
    w(2400);
    diag(0, CDP_NO_FAULT_CODE);
    w(200);
    diag(0, CDP_OPEN_LOAD_CODE);
    cond[0].open_load <= 1'b0;
    // status, mask and clear of the interrupt
    cdp_host_model_i.rd(4'h3, v);
    check(32'(v[0]), 32'h1);
    wr(4'h4, 32'h3ff);
    w(2);
    #1 check(32'(irq), 32'h1);
    wr(4'h4, 32'h0);
    w(2);
    #1 check(32'(irq), 32'h0);
    wr(4'h4, 32'h3ff);
    w(2);
    #1 check(32'(irq), 32'h1);
    wr(4'h3, 32'h3ff);
    w(2);
    #1 check(32'(irq), 32'h0);
    // open load turns into short, timer keeps running
    w(1);
    cond[1].open_load <= 1'b1;
    w(1500);
    cond[1].open_load <= 1'b0;
    cond[1].short_ground <= 1'b1;
    w(1100);
    diag(1, CDP_SHORT_GROUND_CODE);
    cond[1].short_ground <= 1'b0;
    // extended blind time, channel 7 only
    wr(4'h0, 32'h1);
    wr(4'h2, 32'h3ff);
    w(1);
    cond[0].open_load <= 1'b1;
    cond[6].open_load <= 1'b1;
    w(40);
    diag(6, CDP_NO_FAULT_CODE);
    w(20);
    diag(6, CDP_OPEN_LOAD_CODE);
    diag(0, CDP_NO_FAULT_CODE);
    cond[0].open_load <= 1'b0;
    cond[6].open_load <= 1'b0;
    wr(4'h0, 32'h3);
    wr(4'h2, 32'h3ff);
    w(1);
    cond[6].open_load <= 1'b1;
    w(80);
    diag(6, CDP_NO_FAULT_CODE);
    w(30);
    diag(6, CDP_OPEN_LOAD_CODE);
    cond[6].open_load <= 1'b0;
    wr(4'h0, 32'h0);
    // overload latch, released by clear, then by a new code
    w(1);
    cdp_host_model_i.chan_in <= 10'h004;
    cond[2].overload <= 1'b1;
    w(1);
    cond[2].overload <= 1'b0;
    w(3);
    pin(2, 1'b0);
    diag(2, CDP_OVERLOAD_FAULT_CODE);
    w(5);
    pin(2, 1'b0);
    wr(4'h2, 32'h4);
    w(2);
    pin(2, 1'b1);
    w(1);
    cond[2].overload <= 1'b1;
    w(1);
    cond[2].overload <= 1'b0;
    cond[2].open_load <= 1'b1;
    w(2600);
    diag(2, CDP_OPEN_LOAD_CODE);
    cond[2].open_load <= 1'b0;
    pin(2, 1'b1);
    // overload arrives while a clear is written
    fork
      wr(4'h2, 32'h8);
      begin
        w(1);
        cond[3].overload <= 1'b1;
        w(1);
        cond[3].overload <= 1'b0;
      end
    join
    diag(3, CDP_OVERLOAD_FAULT_CODE);
    // reverse comparator on channel 4, input held low
    w(1);
    cdp_host_model_i.chan_in <= '0;
    cond[4].rev_cur <= 1'b1;
    w(3);
    pin(4, 1'b0);
    wr(4'h0, 32'h4);
    w(3);
    pin(4, 1'b1);
    w(1);
    cond[4].rev_over <= 1'b1;
    w(3);
    pin(4, 1'b0);
    w(1);
    cond[4].rev_over <= 1'b0;
    w(20);
    pin(4, 1'b0);
    w(1);
    cond[4].rev_cur <= 1'b0;
    w(500);
    cond[4].rev_cur <= 1'b1;
    w(3);
    pin(4, 1'b0);
    w(1);
    cond[4].rev_cur <= 1'b0;
    w(650);
    cond[4].rev_cur <= 1'b1;
    w(3);
    pin(4, 1'b1);
    final_report;
  end
endmodule
`default_nettype wire
